/* File: pkg/tbc_pkg.sv */
// Purpose: shared constants for the timer-two baud / clock-out block
// Assumes: apb register map, one word per register
// Notes: offsets are byte addresses
package tbc_pkg;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_MODE = 8'h04;
  localparam logic [7:0] ADDR_RLDL = 8'h08;
  localparam logic [7:0] ADDR_RLDH = 8'h0c;
  localparam logic [7:0] ADDR_CNTL = 8'h10;
  localparam logic [7:0] ADDR_CNTH = 8'h14;
  localparam logic [7:0] ADDR_MASK = 8'h18;
  localparam logic [7:0] ADDR_STAT = 8'h1c;
  // control and mode register field positions
  localparam int CT_OVF = 7;
  localparam int CT_EXF = 6;
  localparam int CT_RXS = 5;
  localparam int CT_TXS = 4;
  localparam int CT_EXEN = 3;
  localparam int CT_RUN = 2;
  localparam int CT_TCS = 1;
  localparam int CT_CRS = 0;
  localparam int MD_CKOE = 1;
  // mask register field positions
  localparam int IM_GLB = 7;
  localparam int IM_RSV = 6;
  localparam int IM_T2 = 5;
  localparam int IM_SER = 4;
  localparam int IM_T1 = 3;
  localparam int IM_X1 = 2;
  localparam int IM_T0 = 1;
  localparam int IM_X0 = 0;
  localparam logic [7:0] RST_BYTE = 8'h00;
  // oscillator-derived prescale counts at the state and machine rates
  localparam int STATE_DIV = 2;
  localparam int MACH_DIV = 12;
  localparam int BAUD_DIV = 16;
  localparam logic [3:0] MACH_LAST = 4'hb;
endpackage

/* File: pkg/tbc_cnt_if.sv */
// Purpose: carries counter controls and overflow between modules
// Assumes: one clock
// Notes: none
`timescale 1ns/1ps
`default_nettype none
interface tbc_cnt_if;
  logic tick;
  logic load_wr_l;
  logic load_wr_h;
  logic [7:0] wdata;
  logic ovf;
  logic [15:0] count;
  logic [15:0] reload;
  logic reload_en;
  modport ctl (output tick, output load_wr_l, output load_wr_h, output wdata,
    output reload, output reload_en, input ovf, input count);
  modport cnt (input tick, input load_wr_l, input load_wr_h, input wdata,
    input reload, input reload_en, output ovf, output count);
endinterface
`default_nettype wire

/* File: hw/tbc_counter.sv */
// Purpose: 16-bit up counter with auto-reload on rollover
// Assumes: tick is a one-cycle enable
// Notes: software loads bypass the reload path
`timescale 1ns/1ps
`default_nettype none
module tbc_counter (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control side
  tbc_cnt_if.cnt c
);
  typedef struct packed {
    logic [15:0] cnt;
    logic ovf;
  } tbc_cst_t;
  tbc_cst_t st, next_st;
  always_comb
  begin
    next_st = st;
    next_st.ovf = 1'b0;
    if (c.load_wr_l)
    begin
      next_st.cnt[7:0] = c.wdata;
    end
    else if (c.load_wr_h)
    begin
      next_st.cnt[15:8] = c.wdata;
    end
    else if (c.tick)
    begin
      if (st.cnt == 16'hffff)
      begin
        next_st.ovf = 1'b1;
        next_st.cnt = c.reload_en ? c.reload : 16'h0000; // [RULE3] [RULE21]
      end
      else
      begin
        next_st.cnt = st.cnt + 16'h0001;
      end
    end
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st <= '0;
    else
      st <= next_st;
  end
  assign c.ovf = st.ovf;
  assign c.count = st.cnt;
  rollover_reload_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE3]
    (c.tick && c.reload_en && st.cnt == 16'hffff && !c.load_wr_l && !c.load_wr_h)
    |=> (st.cnt == $past(c.reload) && st.ovf))
    else $error("rollover did not reload");
endmodule
`default_nettype wire

/* File: hw/tbc_sync.sv */
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: async input
// Notes: stage one feeds stage two only
`timescale 1ns/1ps
`default_nettype none
module tbc_sync (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pin
  input wire logic pin,
  // filtered level
  output logic level
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } tbc_sst_t;
  tbc_sst_t st, next_st;
  always_comb
  begin
    next_st = st;
    next_st.s1 = pin;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    if (st.s2 == st.s3)
      next_st.lvl = st.s3;
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st <= 4'hf;
    else
      st <= next_st;
  end
  assign level = st.lvl;
endmodule
`default_nettype wire

/* File: hw/tbc_top.sv */
// What this block does
// [RULE1] either clock select enters baud mode
// [RULE2] tx and rx pick timers independently
// [RULE3] high byte rollover reloads full counter
// [RULE4] baud clock is overflow rate over sixteen
// [RULE5] baud ticks half osc, timer twelfth
// [RULE6] reload is high then low bytes
// [RULE7] baud rollover sets no flag, no irq
// [RULE8] baud falling trigger sets flag, no reload
// [RULE9] software stops run before counter access
// [RULE10] clock-out when select clear, enable set
// [RULE11] clock-out is osc over four-times span
// [RULE12] clock-out rollovers raise no interrupt
// [RULE13] baud and clock-out share reload value
// [RULE14] six sources, each masked, global gate
// [RULE15] timer two request is flag or
// [RULE16] flags set at their state phase
// [RULE17] mask bit one enables, fixed layout
// [RULE18] global clear acknowledges nothing
// [RULE19] software writes no reserved ones
// [RULE20] select picks timer two else one
// [RULE21] clock select forces auto-reload
// [RULE22] clock-out toggles every overflow
// Purpose: timer two baud generator, clock-out and interrupt mask
// Assumes: clk is the oscillator; apb slave, 32-bit data
// Notes: capture and up/down counting are left out
//
// Our own choices: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module tbc_top (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pins
  input wire logic external_trigger_pin,
  output logic clock_out_pin,
  output logic clock_out_pin_oe,
  // serial port clocks
  input wire logic timer_one_ovf,
  output logic tx_baud_tick,
  output logic rx_baud_tick,
  // interrupt sources and request
  input wire logic external_irq_zero,
  input wire logic external_irq_one,
  input wire logic overflow_flag_t0,
  input wire logic overflow_flag_t1,
  input wire logic serial_irq,
  output logic [5:0] irq_pending,
  output logic timer_two_irq
);
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] mode;
    logic [7:0] rld_l;
    logic [7:0] rld_h;
    logic [7:0] mask;
    logic [3:0] pre;
    logic [3:0] tx_div;
    logic [3:0] rx_div;
    logic tx_tick;
    logic rx_tick;
    logic ckout;
    logic trig_q;
    logic [31:0] rdata;
  } tbc_st_t;
  tbc_st_t st, next_st;
  tbc_cnt_if ci();
  logic trig_lvl;
  logic baud_mode;
  logic ckout_mode;
  logic tick;
  logic acc;
  logic wr;
  logic [5:0] src;
  tbc_sync u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pin(external_trigger_pin),
    .level(trig_lvl)
  );
  tbc_counter u_cnt (
    .clk(clk),
    .rst_n(rst_n),
    .c(ci.cnt)
  );
  assign baud_mode = st.ctrl[tbc_pkg::CT_RXS] | st.ctrl[tbc_pkg::CT_TXS]; // [RULE1]
  assign ckout_mode = !st.ctrl[tbc_pkg::CT_TCS] && st.mode[tbc_pkg::MD_CKOE]; // [RULE10]
  // baud and clock-out both run at state rate; plain timer at machine rate
  assign tick = st.ctrl[tbc_pkg::CT_RUN] && (((baud_mode || ckout_mode) // [RULE5]
    && st.pre[0] == 1'b1) || st.pre == tbc_pkg::MACH_LAST);
  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign ci.tick = tick;
  assign ci.reload = {st.rld_h, st.rld_l}; // [RULE6] [RULE13]
  // capture is not built, so every mode auto-reloads
  assign ci.reload_en = 1'b1; // [RULE21]
  assign ci.wdata = pwdata[7:0];
  assign ci.load_wr_l = wr && paddr == tbc_pkg::ADDR_CNTL; // [RULE9]
  assign ci.load_wr_h = wr && paddr == tbc_pkg::ADDR_CNTH;
  always_comb
  begin
    next_st = st;
    next_st.tx_tick = 1'b0;
    next_st.rx_tick = 1'b0;
    next_st.trig_q = trig_lvl;
    next_st.pre = (st.pre == tbc_pkg::MACH_LAST) ? 4'h0 : st.pre + 4'h1;
    if (ci.ovf && baud_mode)
    begin
      next_st.tx_div = st.tx_div + 4'h1; // [RULE4]
      next_st.rx_div = st.rx_div + 4'h1;
      next_st.tx_tick = st.tx_div == 4'hf;
      next_st.rx_tick = st.rx_div == 4'hf;
    end
    if (ci.ovf && ckout_mode)
      next_st.ckout = !st.ckout; // [RULE22] [RULE11]
    if (wr)
    begin
      if (paddr == tbc_pkg::ADDR_CTRL)
        next_st.ctrl = pwdata[7:0];
      else if (paddr == tbc_pkg::ADDR_MODE)
        next_st.mode = pwdata[7:0];
      else if (paddr == tbc_pkg::ADDR_RLDL)
        next_st.rld_l = pwdata[7:0];
      else if (paddr == tbc_pkg::ADDR_RLDH)
        next_st.rld_h = pwdata[7:0];
      else if (paddr == tbc_pkg::ADDR_MASK)
        next_st.mask = pwdata[7:0]; // [RULE17]
    end
    // hardware set after the write so a same-cycle event beats the clear
    if (ci.ovf && !baud_mode && !ckout_mode)
      next_st.ctrl[tbc_pkg::CT_OVF] = 1'b1; // [RULE7] [RULE12] [RULE16]
    if (st.ctrl[tbc_pkg::CT_EXEN] && st.trig_q && !trig_lvl)
      next_st.ctrl[tbc_pkg::CT_EXF] = 1'b1; // [RULE8]
    next_st.rdata = 32'h0000_0000;
    if (acc && !pwrite)
    begin
      if (paddr == tbc_pkg::ADDR_CTRL)
        next_st.rdata = {24'h0, st.ctrl};
      else if (paddr == tbc_pkg::ADDR_MODE)
        next_st.rdata = {24'h0, st.mode};
      else if (paddr == tbc_pkg::ADDR_RLDL)
        next_st.rdata = {24'h0, st.rld_l};
      else if (paddr == tbc_pkg::ADDR_RLDH)
        next_st.rdata = {24'h0, st.rld_h};
      else if (paddr == tbc_pkg::ADDR_CNTL)
        next_st.rdata = {24'h0, ci.count[7:0]};
      else if (paddr == tbc_pkg::ADDR_CNTH)
        next_st.rdata = {24'h0, ci.count[15:8]};
      else if (paddr == tbc_pkg::ADDR_MASK)
        next_st.rdata = {24'h0, st.mask};
      else if (paddr == tbc_pkg::ADDR_STAT)
        next_st.rdata = {26'h0, src};
    end
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st <= '0;
      st.trig_q <= 1'b1;
    end
    else
      st <= next_st;
  end
  // read data registered, so the access phase takes one wait cycle
  logic rd_wait;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rd_wait <= 1'b0;
    else
      rd_wait <= acc && !pwrite && !rd_wait;
  end
  assign pready = pwrite ? 1'b1 : rd_wait;
  assign prdata = st.rdata;
  assign pslverr = 1'b0;
  assign src = {st.ctrl[tbc_pkg::CT_OVF] | st.ctrl[tbc_pkg::CT_EXF], // [RULE15]
    serial_irq, overflow_flag_t1, external_irq_one, overflow_flag_t0, external_irq_zero};
  // reserved bit six skipped; mask bits 5..0 line up with src
  assign irq_pending = st.mask[tbc_pkg::IM_GLB] ? (src & st.mask[5:0]) : 6'h00; // [RULE14] [RULE18]
  assign timer_two_irq = irq_pending[5];
  // timer one keeps feeding a direction whose select is clear
  assign tx_baud_tick = st.ctrl[tbc_pkg::CT_TXS] ? st.tx_tick : timer_one_ovf; // [RULE2] [RULE20]
  assign rx_baud_tick = st.ctrl[tbc_pkg::CT_RXS] ? st.rx_tick : timer_one_ovf; // [RULE20]
  assign clock_out_pin = st.ckout;
  assign clock_out_pin_oe = ckout_mode;
  baud_no_flag_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE7]
    (ci.ovf && baud_mode && !st.ctrl[tbc_pkg::CT_OVF] && !wr)
    |=> !st.ctrl[tbc_pkg::CT_OVF])
    else $error("baud rollover set overflow flag");
  ckout_toggle_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE22]
    (ci.ovf && ckout_mode) |=> clock_out_pin != $past(clock_out_pin))
    else $error("clock-out did not toggle");
  global_gate_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE18]
    !st.mask[tbc_pkg::IM_GLB] |-> irq_pending == 6'h00)
    else $error("request with global enable clear");
  t2_or_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE15]
    (st.mask[7] && st.mask[5] && st.ctrl[tbc_pkg::CT_EXF]) |-> timer_two_irq)
    else $error("external flag not requesting");
  exf_set_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE8]
    (st.ctrl[tbc_pkg::CT_EXEN] && st.trig_q && !trig_lvl)
    |=> st.ctrl[tbc_pkg::CT_EXF])
    else $error("falling trigger missed");
  baud_rate_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE5]
    (tick && baud_mode) |=> !tick)
    else $error("baud tick faster than half rate");
  tx_sel_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE20]
    !st.ctrl[tbc_pkg::CT_TXS] |-> tx_baud_tick == timer_one_ovf)
    else $error("tx not on timer one");
  mode_entry_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE1]
    ((st.ctrl[tbc_pkg::CT_RXS] ^ st.ctrl[tbc_pkg::CT_TXS]) && st.ctrl[tbc_pkg::CT_RUN]
    && !tick && !wr) |=> tick)
    else $error("single select did not enter baud mode");
  // several-step behaviours built from named sequences
  sequence trig_fall_s;
    st.ctrl[tbc_pkg::CT_EXEN] && st.trig_q && !trig_lvl;
  endsequence
  sequence quiet_cnt_s;
    baud_mode && !tick && !ci.load_wr_l && !ci.load_wr_h;
  endsequence
  sequence plain_ovf_s;
    ci.ovf && !baud_mode && !ckout_mode;
  endsequence
  // a write can change the mode, so write cycles are left out
  sequence baud_run_s;
    baud_mode && st.ctrl[tbc_pkg::CT_RUN] && !wr;
  endsequence
  sequence ckout_ovf_s;
    ci.ovf && ckout_mode && !wr;
  endsequence
  trig_no_reload_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE8]
    trig_fall_s ##0 quiet_cnt_s
    |=> ci.count == $past(ci.count))
    else $error("trigger changed the baud counter");
  plain_flag_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE16]
    plain_ovf_s |=> st.ctrl[tbc_pkg::CT_OVF])
    else $error("timer rollover left flag clear");
  half_rate_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE5]
    baud_run_s ##0 !tick |=> tick)
    else $error("baud tick slower than half rate");
  ckout_no_flag_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE12]
    ckout_ovf_s ##0 !st.ctrl[tbc_pkg::CT_OVF]
    |=> !st.ctrl[tbc_pkg::CT_OVF])
    else $error("clock-out rollover set overflow flag");
  ovf_tick_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE3]
    ci.ovf |-> $past(tick))
    else $error("rollover without a tick");
  reload_value_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE6] [RULE13]
    ci.ovf |-> ci.count == $past(ci.reload))
    else $error("counter not at shared reload value");
  tx_div_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE4]
    st.tx_tick
    |-> $past(ci.ovf) && $past(baud_mode) && $past(st.tx_div) == 4'hf)
    else $error("tx tick not on sixteenth rollover");
  rx_div_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE4]
    st.rx_tick
    |-> $past(ci.ovf) && $past(baud_mode) && $past(st.rx_div) == 4'hf)
    else $error("rx tick not on sixteenth rollover");
  rx_sel_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE20]
    !st.ctrl[tbc_pkg::CT_RXS] |-> rx_baud_tick == timer_one_ovf)
    else $error("rx not on timer one");
  rx_t2_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE20] [RULE2]
    (st.ctrl[tbc_pkg::CT_RXS] && rx_baud_tick) |-> $past(ci.ovf))
    else $error("rx tick without timer two rollover");
  run_stop_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE10]
    !st.ctrl[tbc_pkg::CT_RUN] |-> !tick)
    else $error("tick with run bit clear");
  mach_rate_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE5]
    (tick && !baud_mode && !ckout_mode) |-> st.pre == tbc_pkg::MACH_LAST)
    else $error("plain timer tick off machine rate");
  ckout_hold_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE10]
    !(ci.ovf && ckout_mode) |=> clock_out_pin == $past(clock_out_pin))
    else $error("clock-out moved without rollover");
  flags_held_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE15]
    (st.ctrl[tbc_pkg::CT_OVF] && !wr) |=> st.ctrl[tbc_pkg::CT_OVF])
    else $error("overflow flag cleared by hardware");
  exf_held_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE15]
    (st.ctrl[tbc_pkg::CT_EXF] && !wr) |=> st.ctrl[tbc_pkg::CT_EXF])
    else $error("external flag cleared by hardware");
  t2_ovf_req_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE15]
    (st.mask[tbc_pkg::IM_GLB] && st.mask[tbc_pkg::IM_T2] && st.ctrl[tbc_pkg::CT_OVF])
    |-> timer_two_irq)
    else $error("overflow flag not requesting");
  // one pair of checks per source bit; mask bit six is reserved
  for (genvar g = 0; g < 6; g++)
  begin : gate_g
    src_gate_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE14] [RULE17]
      irq_pending[g] |-> src[g] && st.mask[g] && st.mask[tbc_pkg::IM_GLB])
      else $error("pending source not enabled");
    src_pass_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE14] [RULE17]
      (src[g] && st.mask[g] && st.mask[tbc_pkg::IM_GLB]) |-> irq_pending[g])
      else $error("enabled source not pending");
  end
endmodule
`default_nettype wire

/* File: tb/tbc_partner.sv */
// Purpose: timer one and serial receiver stand-in
// Assumes: one clock, pulses last one cycle
// Notes: counts are compared by the bench, not here
`timescale 1ns/1ps
`default_nettype none
module tbc_partner #(parameter int T1_DIV = 7) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // serial side
  input wire logic rx_baud_tick,
  output logic timer_one_ovf,
  output logic [15:0] t1_cnt,
  output logic [15:0] rx_cnt
);
  int div;
  // odd divider so timer one never lines up with timer two
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div <= 0;
      timer_one_ovf <= 1'b0;
      t1_cnt <= 16'h0000;
      rx_cnt <= 16'h0000;
    end
    else
    begin
      div <= (div == T1_DIV - 1) ? 0 : div + 1;
      timer_one_ovf <= (div == T1_DIV - 1);
      t1_cnt <= t1_cnt + 16'(timer_one_ovf);
      rx_cnt <= rx_cnt + 16'(rx_baud_tick);
    end
  end
endmodule
`default_nettype wire

/* File: tb/tb.sv */
// Purpose: self-checking bench for the timer-two block
// Assumes: apb master, 200 MHz clock
// Notes: small reload spans keep the run short
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin failures++; \
  $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module tb;
  logic clk, rst_n, psel, penable, pwrite, pin, sel, last, pready, pslverr;
  logic ck, ck_oe, t1, txt, rxt, t2irq;
  logic [7:0] paddr, m;
  logic [31:0] pwdata, prdata, q;
  logic [4:0] src;
  logic [5:0] pend;
  logic [15:0] t1c, rxc, d0;
  int failures, checks_done, n, seed, span;
  wire watch = sel ? ck : txt;
  tbc_top tbc_top_i (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .external_trigger_pin(pin), .clock_out_pin(ck),
    .clock_out_pin_oe(ck_oe), .timer_one_ovf(t1), .tx_baud_tick(txt), .rx_baud_tick(rxt),
    .external_irq_zero(src[0]), .external_irq_one(src[1]), .overflow_flag_t0(src[2]),
    .overflow_flag_t1(src[3]), .serial_irq(src[4]), .irq_pending(pend),
    .timer_two_irq(t2irq));
  tbc_partner tbc_partner_i (.clk(clk), .rst_n(rst_n), .rx_baud_tick(rxt),
    .timer_one_ovf(t1), .t1_cnt(t1c), .rx_cnt(rxc));
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) last <= watch;
  function automatic logic [5:0] exp_pend(input logic [7:0] k, input logic [4:0] s);
    return k[7] ? ({1'b0, s[4], s[3], s[1], s[2], s[0]} & k[5:0]) : 6'h00;
  endfunction
  task close_out;
    if (failures == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task tmo;
    failures++;
    close_out();
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge clk);
      i++;
    end
    while (pready !== 1'b1 && i < 50);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 50)
      tmo();
  endtask
  // rising edge of the watched signal, period left in n
  task edge_wait;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (!(watch === 1'b1 && last === 1'b0) && n < 9000);
    if (n == 9000)
      tmo();
  endtask
  // lands a fixed distance after a timer one pulse so counts line up
  task t1_sync;
    int i;
    i = 0;
    while (t1 !== 1'b1 && i < 50)
    begin
      @(posedge clk);
      i++;
    end
    repeat (3) @(posedge clk);
  endtask
  task load(input logic [7:0] ctl, input logic [7:0] md);
    logic [15:0] r;
    r = 16'(65536 - span);
    apb(1'b1, tbc_pkg::ADDR_CTRL, 32'h0);
    apb(1'b1, tbc_pkg::ADDR_RLDL, {24'h0, r[7:0]});
    apb(1'b1, tbc_pkg::ADDR_RLDH, {24'h0, r[15:8]});
    apb(1'b1, tbc_pkg::ADDR_CNTL, {24'h0, r[7:0]});
    apb(1'b1, tbc_pkg::ADDR_CNTH, {24'h0, r[15:8]});
    apb(1'b1, tbc_pkg::ADDR_MODE, {24'h0, md});
    apb(1'b1, tbc_pkg::ADDR_CTRL, {24'h0, ctl});
  endtask
  initial
  begin
    seed = 32'hadbb;
    {psel, penable, pwrite, sel} = 4'h0;
    pin = 1'b1;
    paddr = 8'h00;
    pwdata = 32'h0;
    src = 5'h00;
    failures = 0;
    checks_done = 0;
    rst_n = 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, tbc_pkg::ADDR_CTRL, 32'h0);
    `CHK(q, {24'h0, tbc_pkg::RST_BYTE})
    apb(1'b0, tbc_pkg::ADDR_MASK, 32'h0);
    `CHK(q, {24'h0, tbc_pkg::RST_BYTE})
    apb(1'b0, 8'h20, 32'h0);
    `CHK(q, 32'h0)
    `CHK(pslverr, 1'b0)
    for (int k = 0; k < 8; k++)
    begin
      // reserved bit kept clear
      m = (k == 0) ? 8'h3f : 8'($random(seed)) & 8'hbf;
      src <= 5'($random(seed));
      apb(1'b1, tbc_pkg::ADDR_MASK, {24'h0, m});
      apb(1'b0, tbc_pkg::ADDR_MASK, 32'h0);
      `CHK(q[7:0], m)
      `CHK(pend, exp_pend(m, src))
    end
    apb(1'b1, tbc_pkg::ADDR_MASK, 32'ha0);
    repeat (2)
    begin
      span = 2 + ($random(seed) & 7);
      load(8'h14, 8'h02);
      sel = 1'b0;
      repeat (3) edge_wait;
      `CHK(n, 32 * span)
      sel = 1'b1;
      repeat (3) edge_wait;
      `CHK(n, 4 * span)
      `CHK(ck_oe, 1'b1)
      `CHK(t2irq, 1'b0)
      apb(1'b0, tbc_pkg::ADDR_CTRL, 32'h0);
      `CHK(q[7], 1'b0)
      t1_sync();
      d0 = rxc - t1c;
      repeat (60) @(posedge clk);
      t1_sync();
      `CHK(16'(rxc - t1c), d0)
    end
    // plain timer: twelve clocks per count, flag and request raised
    span = 4;
    load(8'h04, 8'h00);
    `CHK(ck_oe, 1'b0)
    apb(1'b0, tbc_pkg::ADDR_CTRL, 32'h0);
    `CHK(q[7], 1'b0)
    repeat (80) @(posedge clk);
    apb(1'b0, tbc_pkg::ADDR_CTRL, 32'h0);
    `CHK(q[7], 1'b1)
    `CHK(t2irq, 1'b1)
    // a rollover in the clearing cycle wins, so clear again once stopped
    apb(1'b1, tbc_pkg::ADDR_CTRL, 32'h0);
    apb(1'b1, tbc_pkg::ADDR_CTRL, 32'h0);
    // the write lands at the edge the task returns on; look one edge later
    @(posedge clk);
    `CHK(t2irq, 1'b0)
    // baud via receive select, falling trigger
    load(8'h2c, 8'h00);
    @(posedge clk);
    pin <= 1'b0;
    repeat (8) @(posedge clk);
    apb(1'b0, tbc_pkg::ADDR_CTRL, 32'h0);
    `CHK(q[7:6], 2'b01)
    `CHK(t2irq, 1'b1)
    // receive now rides timer two: three baud periods give three ticks
    d0 = rxc;
    repeat (96 * span) @(posedge clk);
    `CHK(16'(rxc - d0), 16'h0003)
    pin <= 1'b1;
    close_out();
  end
endmodule
`default_nettype wire
